// file: logic/intc_pkg.sv
// Constants, register map and carrier types of the vectored interrupt controller
package intc_pkg;
	localparam int NUM_VECTORS       = 78;
	localparam int NUM_FLAG_REGS     = 5;
	localparam int NUM_PRIO_REGS     = 21;
	localparam int NUM_EXT           = 3;
	localparam int DATA_W            = 16;
	localparam int ADDR_W            = 6;
	localparam int VEC_W             = 7;
	localparam int LEVEL_W           = 4;
	localparam int PROG_ADDR_W       = 24;
	localparam int NUM_TRAPS         = 8;

	// Register indices on the software port
	localparam logic [5:0] FLAG_BASE    = 6'h00;
	localparam logic [5:0] ENABLE_BASE  = 6'h05;
	localparam logic [5:0] PRIO_BASE    = 6'h0a;
	localparam logic [5:0] CTRL_ONE     = 6'h20;
	localparam logic [5:0] CTRL_TWO     = 6'h21;
	localparam logic [5:0] TEST_REG     = 6'h22;
	localparam logic [5:0] CPU_STATUS   = 6'h23;
	localparam logic [5:0] CPU_CONTROL  = 6'h24;

	// Field positions
	localparam int NEST_DIS_BIT      = 15;
	localparam int ARITH_TRAP_BIT    = 4;
	localparam int ADDR_TRAP_BIT     = 3;
	localparam int STACK_TRAP_BIT    = 2;
	localparam int CLKFAIL_TRAP_BIT  = 1;
	localparam int ALT_TABLE_BIT     = 15;
	localparam int CPU_LEVEL_LSB     = 5;
	localparam int CPU_LEVEL_TOP_BIT = 3;
	localparam int TEST_LEVEL_LSB    = 8;

	// Trap vector numbers
	localparam logic [2:0] TRAP_CLKFAIL = 3'h1;
	localparam logic [2:0] TRAP_ADDR    = 3'h2;
	localparam logic [2:0] TRAP_STACK   = 3'h3;
	localparam logic [2:0] TRAP_ARITH   = 3'h4;

	// Program memory layout of the two tables
	localparam logic [23:0] RESET_ADDR     = 24'h000000;
	localparam logic [23:0] TRAP_TABLE     = 24'h000004;
	localparam logic [23:0] USER_TABLE     = 24'h000014;
	localparam logic [23:0] ALT_OFFSET     = 24'h000100;
	localparam logic [2:0]  LEVEL_BLOCKED  = 3'h7;
	localparam logic [15:0] RESET_VALUE    = 16'h0000;

	// Request presented to the CPU core
	typedef struct packed {
		logic                   valid;
		logic                   is_trap;
		logic [VEC_W-1:0]       vector;
		logic [LEVEL_W-1:0]     level;
		logic [PROG_ADDR_W-1:0] addr;
	} cpu_request_s;

	// Software register port
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_access_s;
endpackage

// file: logic/intc_arbiter.sv
// Combinational priority arbiter over flagged and enabled user sources
`timescale 1ns/1ps
module intc_arbiter #(
	parameter int N = 78
) (
	input  wire logic [N-1:0]   active,
	input  wire logic [3*N-1:0] prio,
	input  wire logic [2:0]     cpu_level,
	output logic                found,
	output logic [6:0]          vector,
	output logic [2:0]          level
);
	import intc_pkg::*;

	// Scan from the top vector down so that the lowest vector wins a tie
	always_comb begin
		found  = 1'b0;
		vector = 7'h00;
		level  = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (active[i] && prio[3*i +: 3] > cpu_level &&
				(!found || prio[3*i +: 3] >= level)) begin
				found  = 1'b1;
				vector = 7'(i);
				level  = prio[3*i +: 3];
			end
		end
	end
endmodule

// file: logic/intc_top.sv
// Vectored interrupt controller: registers, edge detect, traps and request output
//
// Overview of operation
// - Reset clears registers, fetch starts at zero
// - Reset bypasses arbitration and vector lookup
// - Eight trap vectors at 04h, alternate 104h
// - User vector n at 14h+2n, up to 77
// - Flag, enable, priority placed in vector order
// - Five flag, enable; sparse priority registers
// - Flags set by source, cleared by software
// - Disabled sources never request the CPU
// - Each source but vectors 52-59 and 68-71 has writable 3-bit priority
// - Control one: nesting disable, trap flags
// - Control two: edge polarity, table select
// - CPU level low bits writable at 7:5
// - CPU level top bit read only
// - Latch vector and level on request
// - Natural order follows vector number
// - Equal priority: lower table address wins
// - Alternate select redirects every vector fetch
// - Level seven blocks all user interrupts
// - Polarity one negative edge, zero positive
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module intc_top #(
	// One bit per user vector; a cleared bit keeps that vector's flag at zero for good
	parameter logic [77:0] IMPLEMENTED = 78'h210e_4006_22e3_fe1f_3fef
) (
	input  wire logic                           MCLK,
	input  wire logic                           RST,
	input  wire intc_pkg::reg_access_s          REG,
	output logic [intc_pkg::DATA_W-1:0]         RDATA,
	input  wire logic [intc_pkg::NUM_VECTORS-1:0] SOURCE_EVENT,
	input  wire logic [intc_pkg::NUM_EXT-1:0]   EXT_PIN,
	input  wire logic [3:0]                     TRAP_EVENT,
	input  wire logic                           CPU_ACK,
	output intc_pkg::cpu_request_s              CPU_REQ,
	output logic [intc_pkg::PROG_ADDR_W-1:0]    RESET_PC
);
	import intc_pkg::*;

	localparam logic [6:0] EXT_VEC [NUM_EXT] = '{7'd0, 7'd20, 7'd29};

	logic [NUM_VECTORS-1:0]   flag, next_flag;
	logic [NUM_VECTORS-1:0]   enable, next_enable;
	logic [3*NUM_VECTORS-1:0] prio, next_prio;
	logic                     nest_dis, next_nest_dis;
	logic [3:0]               trap_flag, next_trap_flag;
	logic                     alt_sel, next_alt_sel;
	logic [NUM_EXT-1:0]       polarity, next_polarity;
	logic [2:0]               cpu_low, next_cpu_low;
	logic                     cpu_top, next_cpu_top;
	logic [VEC_W-1:0]         test_vec, next_test_vec;
	logic [LEVEL_W-1:0]       test_lvl, next_test_lvl;
	logic [DATA_W-1:0]        next_rdata;
	cpu_request_s             req, next_req;
	logic [NUM_EXT-1:0]       pin_s1, pin_s2, pin_s3;
	logic                     arb_found;
	logic [6:0]               arb_vec;
	logic [2:0]               arb_lvl;

	// Whether a priority register index is implemented; 13, 14 and 17 are not
	function automatic logic prio_reg_ok(input logic [5:0] r);
		return r < 6'(NUM_PRIO_REGS) && r != 6'd13 && r != 6'd14 && r != 6'd17;
	endfunction

	// Handler address from table base and vector; alternate adds a fixed offset
	function automatic logic [23:0] table_addr(input logic [23:0] base,
		input logic [6:0] v, input logic alt);
		return base + {16'h0000, v, 1'b0} + (alt ? ALT_OFFSET : 24'h000000);
	endfunction

	// One 16-bit word of a per-vector bit array; bits past the top vector read 0.
	// The last word is only partly backed, so a plain part-select would run off the end.
	function automatic logic [15:0] word_of(input logic [NUM_VECTORS-1:0] bits,
		input logic [5:0] w);
		logic [15:0] r;
		r = 16'h0000;
		for (int b = 0; b < 16; b++) begin
			if (16*w + b < NUM_VECTORS) begin
				r[b] = bits[16*w + b];
			end
		end
		return r;
	endfunction

	// Per-vector bit array with one 16-bit word replaced; bits past the top are dropped
	function automatic logic [NUM_VECTORS-1:0] put_word(input logic [NUM_VECTORS-1:0] bits,
		input logic [5:0] w, input logic [15:0] d);
		logic [NUM_VECTORS-1:0] r;
		r = bits;
		for (int b = 0; b < 16; b++) begin
			if (16*w + b < NUM_VECTORS) begin
				r[16*w + b] = d[b];
			end
		end
		return r;
	endfunction

	// Three-stage pin sampler; first stage feeds only the second
	always_ff @(posedge MCLK) begin
		if (RST) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end else begin
			pin_s1 <= EXT_PIN;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	intc_arbiter #(.N(NUM_VECTORS)) u_arb (
		.active    (flag & enable & IMPLEMENTED),
		.prio      (prio),
		.cpu_level (cpu_low),
		.found     (arb_found),
		.vector    (arb_vec),
		.level     (arb_lvl)
	);

	// Next state of every register: hardware sets beat software clears
	always_comb begin
		logic [5:0] ri;
		logic [5:0] idx;
		logic [3:0] trap_pick;
		ri             = REG.addr;
		idx            = 6'h00;
		trap_pick      = 4'h0;
		next_flag      = flag;
		next_enable    = enable;
		next_prio      = prio;
		next_nest_dis  = nest_dis;
		next_trap_flag = trap_flag;
		next_alt_sel   = alt_sel;
		next_polarity  = polarity;
		next_cpu_low   = cpu_low;
		next_cpu_top   = cpu_top;
		next_test_vec  = test_vec;
		next_test_lvl  = test_lvl;
		next_req       = req;
		next_rdata     = RESET_VALUE;

		// Software writes
		if (REG.wr) begin
			if (ri < ENABLE_BASE) begin
				next_flag = put_word(flag, ri, REG.wdata);
			end else if (ri < PRIO_BASE) begin
				idx = ri - ENABLE_BASE;
				next_enable = put_word(enable, idx, REG.wdata);
			end else if (ri < PRIO_BASE + 6'(NUM_PRIO_REGS)) begin
				idx = ri - PRIO_BASE;
				if (prio_reg_ok(idx)) begin
					for (int k = 0; k < 4; k++) begin
						if (4*idx + k < NUM_VECTORS) begin
							next_prio[3*(4*idx+k) +: 3] = REG.wdata[4*k +: 3];
						end
					end
				end
			end else if (ri == CTRL_ONE) begin
				next_nest_dis  = REG.wdata[NEST_DIS_BIT];
				// Same bit order as the trap event input: clock, address, stack, arithmetic
				next_trap_flag = {REG.wdata[ARITH_TRAP_BIT], REG.wdata[STACK_TRAP_BIT],
					REG.wdata[ADDR_TRAP_BIT], REG.wdata[CLKFAIL_TRAP_BIT]};
			end else if (ri == CTRL_TWO) begin
				next_alt_sel  = REG.wdata[ALT_TABLE_BIT];
				next_polarity = REG.wdata[NUM_EXT-1:0];
			end else if (ri == CPU_STATUS && !nest_dis) begin
				// Low bits become read only while nesting is disabled
				next_cpu_low = REG.wdata[CPU_LEVEL_LSB +: 3];
			end
			// CPU control top bit ignores writes on purpose
		end

		// Hardware event sets, applied after clears so that a set wins
		next_flag = next_flag | SOURCE_EVENT;
		for (int e = 0; e < NUM_EXT; e++) begin
			if ((polarity[e] && pin_s3[e] && !pin_s2[e]) ||
				(!polarity[e] && !pin_s3[e] && pin_s2[e])) begin
				next_flag[EXT_VEC[e]] = 1'b1;
			end
		end
		next_flag = next_flag & IMPLEMENTED;
		next_trap_flag = next_trap_flag | TRAP_EVENT;

		// Request handshake with the core
		if (req.valid) begin
			if (CPU_ACK) begin
				next_req.valid = 1'b0;
				next_cpu_top   = req.level[3];
				if (!req.level[3]) begin
					next_cpu_low = req.level[2:0];
				end
				// Flags are left alone on acceptance: the handler clears its own
				// source by software, and the raised level keeps it from firing again
			end
		end else if (trap_flag != 4'h0 && !cpu_top) begin
			// Fixed trap order: clock fail first, then address, stack, arithmetic
			if (trap_flag[0]) trap_pick = {1'b0, TRAP_CLKFAIL};
			else if (trap_flag[1]) trap_pick = {1'b0, TRAP_ADDR};
			else if (trap_flag[2]) trap_pick = {1'b0, TRAP_STACK};
			else trap_pick = {1'b0, TRAP_ARITH};
			next_req.valid   = 1'b1;
			next_req.is_trap = 1'b1;
			next_req.vector  = {3'h0, trap_pick};
			next_req.level   = 4'h8 | {1'b0, trap_pick[2:0]};
			next_req.addr    = table_addr(TRAP_TABLE, {3'h0, trap_pick}, alt_sel);
			next_test_vec    = {3'h0, trap_pick};
			next_test_lvl    = 4'h8 | {1'b0, trap_pick[2:0]};
		end else if (arb_found && cpu_low != LEVEL_BLOCKED && !cpu_top) begin
			next_req.valid   = 1'b1;
			next_req.is_trap = 1'b0;
			next_req.vector  = arb_vec;
			next_req.level   = {1'b0, arb_lvl};
			next_req.addr    = table_addr(USER_TABLE, arb_vec, alt_sel);
			next_test_vec    = arb_vec;
			next_test_lvl    = {1'b0, arb_lvl};
		end

		// Read data, one cycle after the strobe
		if (REG.rd) begin
			if (ri < ENABLE_BASE) begin
				next_rdata = word_of(flag, ri);
			end else if (ri < PRIO_BASE) begin
				idx = ri - ENABLE_BASE;
				next_rdata = word_of(enable, idx);
			end else if (ri < PRIO_BASE + 6'(NUM_PRIO_REGS)) begin
				idx = ri - PRIO_BASE;
				if (prio_reg_ok(idx)) begin
					for (int k = 0; k < 4; k++) begin
						if (4*idx + k < NUM_VECTORS) begin
							next_rdata[4*k +: 3] = prio[3*(4*idx+k) +: 3];
						end
					end
				end
			end else if (ri == CTRL_ONE) begin
				next_rdata[NEST_DIS_BIT]     = nest_dis;
				next_rdata[ARITH_TRAP_BIT]   = trap_flag[3];
				next_rdata[ADDR_TRAP_BIT]    = trap_flag[1];
				next_rdata[STACK_TRAP_BIT]   = trap_flag[2];
				next_rdata[CLKFAIL_TRAP_BIT] = trap_flag[0];
			end else if (ri == CTRL_TWO) begin
				next_rdata[ALT_TABLE_BIT]  = alt_sel;
				next_rdata[NUM_EXT-1:0]    = polarity;
			end else if (ri == TEST_REG) begin
				next_rdata[VEC_W-1:0]                    = test_vec;
				next_rdata[TEST_LEVEL_LSB +: LEVEL_W]    = test_lvl;
			end else if (ri == CPU_STATUS) begin
				next_rdata[CPU_LEVEL_LSB +: 3] = cpu_low;
			end else if (ri == CPU_CONTROL) begin
				next_rdata[CPU_LEVEL_TOP_BIT] = cpu_top;
			end
		end
	end

	// Register stage; reset clears everything without any vector lookup
	always_ff @(posedge MCLK) begin
		if (RST) begin
			flag      <= '0;
			enable    <= '0;
			prio      <= '0;
			nest_dis  <= 1'b0;
			trap_flag <= 4'h0;
			alt_sel   <= 1'b0;
			polarity  <= '0;
			cpu_low   <= 3'h0;
			cpu_top   <= 1'b0;
			test_vec  <= '0;
			test_lvl  <= '0;
			req       <= '0;
			RDATA     <= RESET_VALUE;
			CPU_REQ   <= '0;
			RESET_PC  <= RESET_ADDR;
		end else begin
			flag      <= next_flag;
			enable    <= next_enable;
			prio      <= next_prio;
			nest_dis  <= next_nest_dis;
			trap_flag <= next_trap_flag;
			alt_sel   <= next_alt_sel;
			polarity  <= next_polarity;
			cpu_low   <= next_cpu_low;
			cpu_top   <= next_cpu_top;
			test_vec  <= next_test_vec;
			test_lvl  <= next_test_lvl;
			req       <= next_req;
			RDATA     <= next_rdata;
			CPU_REQ   <= next_req;
			RESET_PC  <= RESET_ADDR;
		end
	end
endmodule

// file: verification/intc_chk.sv
// Concurrent checks on the request and register ports of the controller
`timescale 1ns/1ps
module intc_chk #(
	parameter logic [77:0] IMPLEMENTED = '0
) (
	input wire logic                             MCLK,
	input wire logic                             RST,
	input wire intc_pkg::reg_access_s            REG,
	input wire logic [intc_pkg::DATA_W-1:0]      RDATA,
	input wire logic                             CPU_ACK,
	input wire intc_pkg::cpu_request_s           CPU_REQ,
	input wire logic [intc_pkg::PROG_ADDR_W-1:0] RESET_PC
);
	import intc_pkg::*;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// Reset and register port
	a_fetch_zero: assert property (RESET_PC == RESET_ADDR) else $error("fetch addr");
	a_reset_quiet: assert property ($fell(RST) |-> !CPU_REQ.valid && RDATA == '0)
		else $error("busy after reset");
	a_read_window: assert property (RDATA != '0 |-> $past(REG.rd)) else $error("stray data");
	// Request hand-shake: held until taken, then dropped
	a_req_holds: assert property (CPU_REQ.valid && !CPU_ACK |=> $stable(CPU_REQ))
		else $error("request moved");
	a_ack_drops: assert property (CPU_REQ.valid && CPU_ACK |=> !CPU_REQ.valid)
		else $error("request kept");
	// Slot addresses and trap levels follow the vector number
	a_user_slot: assert property (CPU_REQ.valid && !CPU_REQ.is_trap |->
		CPU_REQ.addr[7:0] == 8'h14 + {CPU_REQ.vector, 1'b0} && CPU_REQ.addr[23:9] == '0)
		else $error("user slot");
	a_trap_slot: assert property (CPU_REQ.valid && CPU_REQ.is_trap |->
		CPU_REQ.addr[7:0] == 8'h04 + {CPU_REQ.vector[3:0], 1'b0} &&
		CPU_REQ.level == 4'h8 + CPU_REQ.vector[3:0]) else $error("trap slot");
	a_impl_only: assert property (CPU_REQ.valid && !CPU_REQ.is_trap |->
		IMPLEMENTED[CPU_REQ.vector]) else $error("absent vector");
	a_user_level: assert property (CPU_REQ.valid && !CPU_REQ.is_trap |->
		!CPU_REQ.level[3] && CPU_REQ.level[2:0] != 3'h0) else $error("user level");
	c_user: cover property (CPU_REQ.valid && !CPU_REQ.is_trap);
	c_trap: cover property (CPU_REQ.valid && CPU_REQ.is_trap);
	c_slow: cover property (CPU_REQ.valid && !CPU_ACK ##1 CPU_REQ.valid);
endmodule
bind intc_top intc_chk #(.IMPLEMENTED(IMPLEMENTED)) chk (.MCLK(MCLK), .RST(RST), .REG(REG),
	.RDATA(RDATA), .CPU_ACK(CPU_ACK), .CPU_REQ(CPU_REQ), .RESET_PC(RESET_PC));

// file: verification/cpu_model.sv
// Behavioural core that takes each request after a short or a long wait
`timescale 1ns/1ps
module cpu_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic valid,
	output logic      ack
);
	logic [2:0] wait_cnt;
	logic [2:0] next_wait_cnt;
	logic       next_ack;
	// Slow mode lets the request stand a few cycles; ack lasts one cycle
	always_comb begin
		next_wait_cnt = (valid && !ack) ? wait_cnt + 3'h1 : 3'h0;
		next_ack = valid && !ack && wait_cnt >= (slow ? 3'h4 : 3'h0);
	end
	always_ff @(posedge clk) begin
		wait_cnt <= rst ? 3'h0 : next_wait_cnt;
		ack <= rst ? 1'b0 : next_ack;
	end
endmodule

// file: verification/vectored_interrupt_controller_test.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
module vectored_interrupt_controller_test;
	import intc_pkg::*;
	typedef struct packed {logic [6:0] v; logic [2:0] p; logic alt;} row_s;
	logic         mclk;
	logic         rst;
	reg_access_s  bus;
	logic [15:0]  rdata;
	logic [77:0]  src;
	logic [2:0]   ext;
	logic [3:0]   trap;
	logic         ack;
	logic         slow;
	cpu_request_s req;
	logic [23:0]  rpc;
	int           n_fail;
	int           comparisons;
	// Ordinary cases: vector, priority, alternate table
	row_s         rows [5] = '{'{7'd0, 3'h1, 1'b0}, '{7'd3, 3'h5, 1'b1}, '{7'd13, 3'h7, 1'b0},
		'{7'd67, 3'h4, 1'b1}, '{7'd77, 3'h2, 1'b0}};
	intc_top DUT (.MCLK(mclk), .RST(rst), .REG(bus), .RDATA(rdata), .SOURCE_EVENT(src),
		.EXT_PIN(ext), .TRAP_EVENT(trap), .CPU_ACK(ack), .CPU_REQ(req), .RESET_PC(rpc));
	cpu_model core (.clk(mclk), .rst(rst), .slow(slow), .valid(req.valid), .ack(ack));
	always #20 mclk = ~mclk;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle strobes; read data is taken in the cycle after the strobe
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus <= '0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
		@(posedge mclk);
		bus <= '0;
		#1 chk({8'h0, rdata}, {8'h0, exp});
	endtask
	task automatic pulse(input logic [77:0] m);
		@(posedge mclk);
		src <= m;
		@(posedge mclk);
		src <= '0;
	endtask
	task automatic setup(input logic [6:0] v, input logic [2:0] p);
		wr(ENABLE_BASE + 6'(v >> 4), 16'h1 << v[3:0]);
		wr(PRIO_BASE + 6'(v >> 2), 16'(p) << {v[1:0], 2'b00});
	endtask
	// Bounded wait for a request, then compare it whole
	task automatic req_is(input logic t, input logic [6:0] v, input logic [3:0] l,
		input logic [23:0] a);
		for (int i = 0; i < 30 && req.valid !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({11'h0, req.valid, req.is_trap, req.vector, req.level}, {11'h0, 1'b1, t, v, l});
		chk(req.addr, a);
	endtask
	// Let the core take it, clear the served flag by software, then lower the level
	task automatic quiet(input logic [5:0] a, input logic [15:0] d);
		for (int i = 0; i < 30 && req.valid !== 1'b0; i++) begin
			@(posedge mclk);
			#1;
		end
		wr(a, d);
		wr(CPU_STATUS, 16'h0);
	endtask
	task automatic idle;
		repeat (8) @(posedge mclk);
		#1 chk({23'h0, req.valid}, 24'h0);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog at 3000 cycles; the run needs well under that
	initial begin
		#120000;
		n_fail++;
		end_of_test;
	end
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		bus = '0;
		src = '0;
		ext = '0;
		trap = '0;
		slow = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1 chk(rpc, RESET_ADDR);
		foreach (rows[i]) begin
			slow <= rows[i].alt;
			wr(CTRL_TWO, {rows[i].alt, 15'h0});
			setup(rows[i].v, rows[i].p);
			pulse(78'h1 << rows[i].v);
			req_is(1'b0, rows[i].v, {1'b0, rows[i].p}, USER_TABLE + 24'(rows[i].v) * 2 +
				(rows[i].alt ? ALT_OFFSET : 24'h0));
			rd(TEST_REG, {4'h0, 1'b0, rows[i].p, 1'b0, rows[i].v});
			rd(FLAG_BASE + 6'(rows[i].v >> 4), 16'h1 << rows[i].v[3:0]);
			quiet(FLAG_BASE + 6'(rows[i].v >> 4), 16'h0);
			rd(FLAG_BASE + 6'(rows[i].v >> 4), 16'h0);
		end
		// Equal priority: lower vector first, the other one after
		wr(ENABLE_BASE, 16'h0024);
		wr(PRIO_BASE, 16'h0300);
		wr(PRIO_BASE + 6'h1, 16'h0030);
		pulse(78'h24);
		req_is(1'b0, 7'd2, 4'h3, 24'h000018);
		quiet(FLAG_BASE, 16'h0020);
		req_is(1'b0, 7'd5, 4'h3, 24'h00001e);
		quiet(FLAG_BASE, 16'h0000);
		// Priority must be strictly above the core level
		wr(CPU_STATUS, 16'h0080);
		setup(7'd3, 3'h4);
		pulse(78'h8);
		idle;
		wr(CPU_STATUS, 16'h0060);
		req_is(1'b0, 7'd3, 4'h4, 24'h00001a);
		quiet(FLAG_BASE, 16'h0000);
		// Disabled source flags only; absent vector never flags
		setup(7'd14, 3'h6);
		pulse(78'h4002);
		idle;
		rd(FLAG_BASE, 16'h0002);
		wr(FLAG_BASE, 16'h0);
		rd(FLAG_BASE, 16'h0);
		wr(ENABLE_BASE, 16'h0);
		// Pin edges of both polarities
		ext <= 3'h1;
		repeat (8) @(posedge mclk);
		rd(FLAG_BASE, 16'h0001);
		wr(FLAG_BASE, 16'h0);
		wr(CTRL_TWO, 16'h0001);
		ext <= 3'h0;
		repeat (8) @(posedge mclk);
		rd(FLAG_BASE, 16'h0001);
		wr(FLAG_BASE, 16'h0);
		rd(6'h3f, 16'h0);
		wr(PRIO_BASE + 6'd13, 16'h7777);
		rd(PRIO_BASE + 6'd13, 16'h0);
		wr(CPU_CONTROL, 16'h0008);
		rd(CPU_CONTROL, 16'h0);
		// Nesting disabled freezes the level bits against software
		wr(CTRL_ONE, 16'h8000);
		wr(CPU_STATUS, 16'h00e0);
		rd(CPU_STATUS, 16'h0000);
		rd(CTRL_ONE, 16'h8000);
		wr(CTRL_ONE, 16'h0000);
		// Level seven blocks users but not a trap
		wr(CPU_STATUS, 16'h00e0);
		rd(CPU_STATUS, 16'h00e0);
		setup(7'd3, 3'h7);
		pulse(78'h8);
		idle;
		@(posedge mclk);
		trap <= 4'h4;
		@(posedge mclk);
		trap <= 4'h0;
		req_is(1'b1, 7'd3, 4'hb, 24'h00000a);
		rd(CTRL_ONE, 16'h0004);
		quiet(FLAG_BASE, 16'h0000);
		rd(CPU_CONTROL, 16'h0008);
		// Reset in mid-run clears everything
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(CPU_CONTROL, 16'h0);
		rd(CTRL_ONE, 16'h0);
		end_of_test;
	end
endmodule
